/* core/hps_pin_select.sv */
// Purpose: function select for shared host-port and enable pins
// Assumes: pins are asynchronous to ref_clk_i and are synchronised here
// Notes:   every top output comes from a flip-flop, so it lags pins by 3
`default_nettype none
module hps_pin_select (
    // Clock and reset
    input  wire  logic                    ref_clk_i,
    input  wire  logic                    rst_n_i,
    // Controller state and pin options
    input  wire  logic                    config_state_i,
    input  wire  logic [3:0]              buck_sel_is_scale_i,
    input  wire  logic                    clk_req_a_is_pi2c_i,
    input  wire  logic                    power_request_pin_is_clk_req_i,
    // Straps
    input  wire  logic                    serial_port_select_i,
    input  wire  logic                    startup_strap_b_i,
    // Load switch pins
    input  wire  logic                    load_switch_pin_a_i,
    input  wire  logic                    load_switch_pin_b_i,
    // Shared serial pins
    input  wire  logic                    sck_pin_i,
    input  wire  logic                    data_pin_i,
    input  wire  logic                    out_pin_i,
    input  wire  logic                    sel_pin_i,
    // Serial engine side
    input  wire  logic                    sda_drive_low_i,
    input  wire  logic                    miso_i,
    input  wire  logic                    general_pin_a_out_i,
    input  wire  logic                    general_pin_a_oe_i,
    input  wire  logic                    general_pin_b_out_i,
    input  wire  logic                    general_pin_b_oe_i,
    // Enable pins
    input  wire  logic [3:0]              buck_select_pin_i,
    input  wire  logic                    clock_request_a_i,
    input  wire  logic                    clock_request_b_i,
    input  wire  logic                    power_request_pin_i,
    // Pin drivers
    output logic                          data_pin_o,
    output logic                          data_pin_oe_o,
    output logic                          out_pin_o,
    output logic                          out_pin_oe_o,
    output logic                          sel_pin_o,
    output logic                          sel_pin_oe_o,
    // Decoded results
    output logic                          i2c_mode_o,
    output hps_pkg::hps_serial_type       serial_o,
    output logic                          general_pin_a_o,
    output logic                          general_pin_b_o,
    output logic                          pins_as_enables_o,
    output hps_pkg::hps_enables_type      enables_o,
    output logic                          pi2c_scl_o,
    output logic                          load_switch_on_bit_a_o,
    output logic                          load_switch_on_bit_b_o
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    localparam int NSYNC = 16;
    logic [NSYNC-1:0] meta_ff;
    logic [NSYNC-1:0] sync_ff;
    logic [NSYNC-1:0] pin_raw;

    assign pin_raw = {serial_port_select_i, startup_strap_b_i,
                      load_switch_pin_a_i, load_switch_pin_b_i,
                      sck_pin_i, data_pin_i, out_pin_i, sel_pin_i,
                      buck_select_pin_i, clock_request_a_i,
                      clock_request_b_i, power_request_pin_i,
                      config_state_i};

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= pin_raw;
            sync_ff <= meta_ff;
        end
    end

    logic       s_port;
    logic       s_strap;
    logic       s_ls_a;
    logic       s_ls_b;
    logic       s_sck;
    logic       s_data;
    logic       s_out;
    logic       s_sel;
    logic [3:0] s_buck;
    logic       s_cra;
    logic       s_crb;
    logic       s_pwr;
    logic       s_cfg;

    assign {s_port, s_strap, s_ls_a, s_ls_b, s_sck, s_data, s_out, s_sel,
            s_buck, s_cra, s_crb, s_pwr, s_cfg} = sync_ff;

    // ****************************************
    // Registered outputs
    // ****************************************
    logic                      i2c_ff;
    logic                      nxt_i2c;
    hps_pkg::hps_port_type     nxt_mode;
    hps_pkg::hps_serial_type   serial_ff;
    hps_pkg::hps_serial_type   nxt_serial;
    hps_pkg::hps_enables_type  en_ff;
    hps_pkg::hps_enables_type  nxt_en;
    logic [5:0] drv_ff;
    logic [5:0] nxt_drv;
    logic       gpa_ff;
    logic       nxt_gpa;
    logic       gpb_ff;
    logic       nxt_gpb;
    logic       pin_en_ff;
    logic       nxt_pin_en;
    logic       pscl_ff;
    logic       nxt_pscl;
    logic       ls_a_ff;
    logic       nxt_ls_a;
    logic       ls_b_ff;
    logic       nxt_ls_b;

    always_comb begin
        nxt_serial = '0;
        nxt_en     = '0;
        nxt_drv    = '0;
        nxt_gpa    = 1'h0;
        nxt_gpb    = 1'h0;
        nxt_pscl   = 1'h0;
        nxt_mode = (s_port == hps_pkg::PORT_I2C) ? hps_pkg::HPS_ST_I2C
                                                  : hps_pkg::HPS_ST_SPI;
        nxt_i2c  = (nxt_mode == hps_pkg::HPS_ST_I2C);
        case (nxt_mode)
            hps_pkg::HPS_ST_I2C: begin
                nxt_serial.scl    = s_sck;
                nxt_serial.sda_in = s_data;
                nxt_drv[1:0]      = {1'h0, sda_drive_low_i};
                nxt_gpa           = s_out;
                nxt_drv[3:2]      = {general_pin_a_out_i, general_pin_a_oe_i};
                nxt_gpb           = s_sel;
                nxt_drv[5:4]      = {general_pin_b_out_i, general_pin_b_oe_i};
            end
            hps_pkg::HPS_ST_SPI: begin
                nxt_serial.sck     = s_sck;
                nxt_serial.mosi    = s_data;
                nxt_serial.chip_en = s_sel;
                nxt_drv[3:2]       = {miso_i, s_sel};
            end
            default: begin
                nxt_drv = '0;
            end
        endcase
        // strap low turns pins into enables
        nxt_pin_en = (s_strap == hps_pkg::STRAP_PIN_SEL);
        if (nxt_pin_en) begin
            // enable or two-level scaling per buck pin; request a is enable or PI2C SCL
            nxt_en.buck_enable     = s_buck & ~buck_sel_is_scale_i;
            nxt_en.buck_scale_high = s_buck & buck_sel_is_scale_i;
            nxt_en.clk_req_a_en    = s_cra & ~clk_req_a_is_pi2c_i;
            nxt_pscl               = s_cra & clk_req_a_is_pi2c_i;
            nxt_en.clk_req_b_en    = s_crb;
            nxt_en.power_request_pin_en      = s_pwr & power_request_pin_is_clk_req_i;
            nxt_en.sleep_req       = s_pwr & ~power_request_pin_is_clk_req_i;
        end
        // copy pin a in config state
        nxt_ls_a = s_cfg ? s_ls_a : ls_a_ff;
        // copy pin b in config state
        nxt_ls_b = s_cfg ? s_ls_b : ls_b_ff;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            i2c_ff    <= hps_pkg::RST_BIT;
            serial_ff <= '0;
            en_ff     <= '0;
            drv_ff    <= '0;
            gpa_ff    <= hps_pkg::RST_BIT;
            gpb_ff    <= hps_pkg::RST_BIT;
            pin_en_ff <= hps_pkg::RST_BIT;
            pscl_ff   <= hps_pkg::RST_BIT;
            ls_a_ff   <= hps_pkg::RST_BIT;
            ls_b_ff   <= hps_pkg::RST_BIT;
        end else begin
            i2c_ff    <= nxt_i2c;
            serial_ff <= nxt_serial;
            en_ff     <= nxt_en;
            drv_ff    <= nxt_drv;
            gpa_ff    <= nxt_gpa;
            gpb_ff    <= nxt_gpb;
            pin_en_ff <= nxt_pin_en;
            pscl_ff   <= nxt_pscl;
            ls_a_ff   <= nxt_ls_a;
            ls_b_ff   <= nxt_ls_b;
        end
    end

    // Open-drain SDA: value bit stays 0, only the enable moves
    assign data_pin_o             = drv_ff[1];
    assign data_pin_oe_o          = drv_ff[0];
    assign out_pin_o              = drv_ff[3];
    assign out_pin_oe_o           = drv_ff[2];
    assign sel_pin_o              = drv_ff[5];
    assign sel_pin_oe_o           = drv_ff[4];
    assign i2c_mode_o             = i2c_ff;
    assign serial_o               = serial_ff;
    assign general_pin_a_o        = gpa_ff;
    assign general_pin_b_o        = gpb_ff;
    assign pins_as_enables_o      = pin_en_ff;
    assign enables_o              = en_ff;
    assign pi2c_scl_o             = pscl_ff;
    assign load_switch_on_bit_a_o = ls_a_ff;
    assign load_switch_on_bit_b_o = ls_b_ff;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence in_cfg_s;
        s_cfg;
    endsequence
    sequence out_cfg_s;
        !s_cfg;
    endsequence

    ls_copy_a_a: assert property (in_cfg_s |=> ls_a_ff == $past(s_ls_a))
        else $error("load switch bit a not copied");
    ls_copy_b_a: assert property (in_cfg_s |=> ls_b_ff == $past(s_ls_b))
        else $error("load switch bit b not copied");
    ls_hold_a_a: assert property (out_cfg_s |=> $stable(ls_a_ff))
        else $error("load switch bit a changed outside config");
    ls_hold_b_a: assert property (out_cfg_s |=> $stable(ls_b_ff))
        else $error("load switch bit b changed outside config");
    port_mode_a: assert property (1'b1 |=> i2c_mode_o == $past(s_port))
        else $error("port mode does not follow select");
    scl_route_a: assert property (s_port |=> serial_o.scl == $past(s_sck)
                                   && serial_o.sck == 1'h0)
        else $error("clock pin misrouted in I2C mode");
    mosi_in_a: assert property (!s_port |=> !data_pin_oe_o)
        else $error("data pin driven in SPI mode");
    miso_drv_a: assert property (!s_port && s_sel |=> out_pin_oe_o
                                  && out_pin_o == $past(miso_i))
        else $error("MISO not driven while addressed");
    ce_gate_a: assert property (!s_port && !s_sel |=> !out_pin_oe_o)
        else $error("MISO driven without chip enable");
    strap_en_a: assert property (s_strap |=> enables_o == '0
                                  && !pins_as_enables_o)
        else $error("enables active with strap high");
    scale_sel_a: assert property (!s_strap |=> enables_o.buck_scale_high
        == ($past(s_buck) & $past(buck_sel_is_scale_i)))
        else $error("scaling level wrong");
    pscl_sel_a: assert property (!s_strap && clk_req_a_is_pi2c_i |=>
                                  !enables_o.clk_req_a_en)
        else $error("request a used as enable in I2C role");
    sleep_sel_a: assert property (!s_strap && !power_request_pin_is_clk_req_i |=>
                                   !enables_o.power_request_pin_en)
        else $error("power request used as clock request");

endmodule : hps_pin_select
`default_nettype wire

/* core/hps_pkg.sv */
// Purpose: shared types and constants for the host port and pin select
// Assumes: one 50 MHz clock, straps static after power-up
// Notes:   no register bus; all control and status are plain ports
`default_nettype none
package hps_pkg;
    // ****************************************
    // Encodings
    // ****************************************
    localparam logic PORT_SPI        = 1'h0;
    localparam logic PORT_I2C        = 1'h1;
    localparam logic STRAP_PIN_SEL   = 1'h0;
    localparam logic RST_BIT         = 1'h0;
    localparam logic [1:0] RST_SEL   = 2'h0;

    typedef enum logic [1:0] {
        HPS_ST_SPI  = 2'h0,
        HPS_ST_I2C  = 2'h1
    } hps_port_type;

    // Serial side as seen by the protocol engines
    typedef struct packed {
        logic scl;
        logic sda_in;
        logic sck;
        logic mosi;
        logic chip_en;
    } hps_serial_type;

    // Pin-derived enables and scaling levels
    typedef struct packed {
        logic [3:0] buck_enable;
        logic [3:0] buck_scale_high;
        logic       clk_req_a_en;
        logic       clk_req_b_en;
        logic       power_request_pin_en;
        logic       sleep_req;
    } hps_enables_type;
endpackage : hps_pkg
`default_nettype wire

/* testbench/hps_host_model.sv */
// Purpose: host-side model of the shared serial and general pins
// Assumes: data line has a pull-up; the read line floats when let go in SPI mode, the select line follows the host
// Notes:   a floating line toggles every cycle so a stale level shows
`default_nettype none
module hps_host_model (
    // Clock and mode
    input  wire  logic ref_clk_i,
    input  wire  logic spi_mode_i,
    // Host drive
    input  wire  logic host_ce_i,
    input  wire  logic host_sda_i,
    input  wire  logic host_gpio_i,
    // Device drive
    input  wire  logic data_pin_oe_i,
    input  wire  logic out_pin_i,
    input  wire  logic out_pin_oe_i,
    input  wire  logic sel_pin_i,
    input  wire  logic sel_pin_oe_i,
    // Resolved wires
    output logic       data_wire_o,
    output logic       out_wire_o,
    output logic       sel_wire_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tgl_ff = 1'b0;
    always @(posedge ref_clk_i) tgl_ff <= ~tgl_ff;
    assign data_wire_o = ~data_pin_oe_i & host_sda_i;
    // read line floats when let go in SPI mode, follows host gpio in I2C mode
    assign out_wire_o = out_pin_oe_i ? out_pin_i
                      : (spi_mode_i ? tgl_ff : host_gpio_i);
    assign sel_wire_o = sel_pin_oe_i ? sel_pin_i : host_ce_i;
endmodule // hps_host_model
`default_nettype wire

/* testbench/testbench.sv */
// Purpose: self-checking bench for the host port and pin select
// Assumes: outputs settle within 4 edges of a pin change
// Notes:   straps change only under reset, as a board would hold them
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, cfg = 1'b0, sps = 1'b0, stb = 1'b1;
    logic lsa = 1'b0, lsb = 1'b0, sck = 1'b0, ce = 1'b0, sda = 1'b1;
    logic gio = 1'b0, sdl = 1'b0, miso = 1'b0, gao = 1'b0, gae = 1'b0;
    logic gbo = 1'b0, gbe = 1'b0;
    logic cra = 1'b0, crb = 1'b0, pwr = 1'b0, pi2c = 1'b0, pclk = 1'b0;
    logic [3:0] buck = 4'h0, scl4 = 4'h0;
    logic dw, ow, sw, d_o, d_oe, o_o, o_oe, s_o, s_oe, i2c, ga, gb;
    logic pae, pscl, bta, btb;
    hps_pkg::hps_serial_type  ser;
    hps_pkg::hps_enables_type en;
    int failures = 0, checks_done = 0, cycles = 0;

    hps_pin_select dut (
        .ref_clk_i(clk), .rst_n_i(rst_n), .config_state_i(cfg),
        .buck_sel_is_scale_i(scl4), .clk_req_a_is_pi2c_i(pi2c),
        .power_request_pin_is_clk_req_i(pclk), .serial_port_select_i(sps),
        .startup_strap_b_i(stb), .load_switch_pin_a_i(lsa),
        .load_switch_pin_b_i(lsb), .sck_pin_i(sck), .data_pin_i(dw),
        .out_pin_i(ow), .sel_pin_i(sw), .sda_drive_low_i(sdl),
        .miso_i(miso), .general_pin_a_out_i(gao),
        .general_pin_a_oe_i(gae), .general_pin_b_out_i(gbo),
        .general_pin_b_oe_i(gbe), .buck_select_pin_i(buck),
        .clock_request_a_i(cra), .clock_request_b_i(crb),
        .power_request_pin_i(pwr), .data_pin_o(d_o), .data_pin_oe_o(d_oe),
        .out_pin_o(o_o), .out_pin_oe_o(o_oe), .sel_pin_o(s_o),
        .sel_pin_oe_o(s_oe), .i2c_mode_o(i2c), .serial_o(ser),
        .general_pin_a_o(ga), .general_pin_b_o(gb),
        .pins_as_enables_o(pae), .enables_o(en), .pi2c_scl_o(pscl),
        .load_switch_on_bit_a_o(bta), .load_switch_on_bit_b_o(btb));

    hps_host_model host (
        .ref_clk_i(clk), .spi_mode_i(~sps), .host_ce_i(ce),
        .host_sda_i(sda), .host_gpio_i(gio), .data_pin_oe_i(d_oe),
        .out_pin_i(o_o), .out_pin_oe_i(o_oe), .sel_pin_i(s_o),
        .sel_pin_oe_i(s_oe), .data_wire_o(dw), .out_wire_o(ow),
        .sel_wire_o(sw));

    initial forever #10 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        // Whole run needs under 400 cycles
        if (cycles == 3000) begin
            failures++;
            stop_test();
        end
    end

    task automatic chk(input string nm, input logic [3:0] ex,
                       input logic [3:0] got);
        checks_done++;
        if (got !== ex) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask

    // straps move only while reset is held
    task automatic reboot(input logic s_v, input logic b_v);
        @(posedge clk);
        rst_n <= 1'b0;
        sps <= s_v;
        stb <= b_v;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        settle();
    endtask

    task automatic t_load();
        @(posedge clk);
        cfg <= 1'b1;
        lsa <= 1'b1;
        settle();
        chk("bit_a", 4'h1, {3'h0, bta});
        chk("bit_b", 4'h0, {3'h0, btb});
        @(posedge clk);
        lsa <= 1'b0;
        lsb <= 1'b1;
        settle();
        chk("bit_a", 4'h0, {3'h0, bta});
        chk("bit_b", 4'h1, {3'h0, btb});
        @(posedge clk);
        cfg <= 1'b0;
        settle();
        @(posedge clk);
        lsa <= 1'b1;
        lsb <= 1'b0;
        settle();
        chk("bit_a_held", 4'h0, {3'h0, bta});
        chk("bit_b_held", 4'h1, {3'h0, btb});
        $display("test load done");
    endtask

    task automatic t_spi();
        @(posedge clk);
        ce <= 1'b1;
        miso <= 1'b1;
        sck <= 1'b1;
        sdl <= 1'b1;
        gbe <= 1'b1;
        settle();
        chk("i2c_mode", 4'h0, {3'h0, i2c});
        chk("sck_scl", 4'h2, {2'h0, ser.sck, ser.scl});
        chk("mosi", 4'h1, {3'h0, ser.mosi});
        chk("data_oe", 4'h0, {3'h0, d_oe});
        chk("miso", 4'h3, {2'h0, o_oe, o_o});
        chk("chip_en", 4'h1, {3'h0, ser.chip_en});
        chk("sel_drv", 4'h0, {2'h0, s_oe, s_o});
        @(posedge clk);
        ce <= 1'b0;
        sdl <= 1'b0;
        gbe <= 1'b0;
        settle();
        chk("ce_off", 4'h0, {2'h0, ser.chip_en, o_oe});
        $display("test spi done");
    endtask

    task automatic t_i2c();
        reboot(1'b1, 1'b1);
        @(posedge clk);
        sda <= 1'b0;
        gio <= 1'b1;
        ce <= 1'b1;
        settle();
        chk("i2c_mode", 4'h1, {3'h0, i2c});
        chk("scl_sck", 4'h2, {2'h0, ser.scl, ser.sck});
        chk("sda_in", 4'h0, {3'h0, ser.sda_in});
        chk("gpins", 4'h3, {2'h0, ga, gb});
        chk("no_ce", 4'h0, {3'h0, ser.chip_en});
        @(posedge clk);
        sda <= 1'b1;
        sdl <= 1'b1;
        gae <= 1'b1;
        gbo <= 1'b1;
        gbe <= 1'b1;
        settle();
        chk("sda_pull", 4'h2, {2'h0, d_oe, ser.sda_in});
        chk("sda_val", 4'h0, {3'h0, d_o});
        chk("gpa_drive", 4'h2, {2'h0, o_oe, o_o});
        chk("gpb_drive", 4'h3, {2'h0, s_oe, s_o});
        @(posedge clk);
        sdl <= 1'b0;
        gae <= 1'b0;
        gbo <= 1'b0;
        gbe <= 1'b0;
        $display("test i2c done");
    endtask

    task automatic t_en();
        reboot(1'b0, 1'b0);
        @(posedge clk);
        scl4 <= 4'h5;
        buck <= 4'hf;
        cra <= 1'b1;
        crb <= 1'b1;
        pwr <= 1'b1;
        pi2c <= 1'b1;
        settle();
        chk("as_enables", 4'h1, {3'h0, pae});
        chk("buck_en", 4'ha, en.buck_enable);
        chk("buck_scale", 4'h5, en.buck_scale_high);
        chk("req_a", 4'h2, {2'h0, pscl, en.clk_req_a_en});
        chk("req_b", 4'h1, {3'h0, en.clk_req_b_en});
        chk("power_request_pin", 4'h1, {2'h0, en.power_request_pin_en, en.sleep_req});
        @(posedge clk);
        pi2c <= 1'b0;
        pclk <= 1'b1;
        settle();
        chk("req_a", 4'h1, {2'h0, pscl, en.clk_req_a_en});
        chk("power_request_pin", 4'h2, {2'h0, en.power_request_pin_en, en.sleep_req});
        reboot(1'b0, 1'b1);
        chk("strap_high", 4'h1, {3'h0, en === '0});
        chk("as_enables", 4'h0, {3'h0, pae});
        $display("test enables done");
    endtask

    task automatic stop_test();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        reboot(1'b0, 1'b1);
        t_load();
        t_spi();
        t_i2c();
        t_en();
        stop_test();
    end
endmodule // testbench
`default_nettype wire
